/* common/shc_pkg.sv */
// constants for the scsi host command and status register block
`default_nettype none
package shc_pkg;
  // ----------------------------------------------------------------
  // bus and storage geometry
  // ----------------------------------------------------------------
  localparam int unsigned SHC_AW     = 4;
  localparam int unsigned SHC_DW     = 8;
  localparam int unsigned SHC_FIFO_W = 9;
  localparam int unsigned SHC_FIFO_D = 16;
  localparam int unsigned SHC_CNT_W  = 17;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] SHC_ADDR_CNT_LO = 4'h0;
  localparam logic [3:0] SHC_ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] SHC_ADDR_FIFO   = 4'h2;
  localparam logic [3:0] SHC_ADDR_CMD    = 4'h3;
  localparam logic [3:0] SHC_ADDR_STAT   = 4'h4;
  localparam logic [3:0] SHC_ADDR_ISR    = 4'h5;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned SHC_CMD_DMA_BIT = 7;
  localparam logic [16:0] SHC_MAX_COUNT   = 17'h10000;
  localparam logic [7:0]  SHC_DOUT_RST    = 8'h00;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] SHC_C_NOP       = 7'h00;
  localparam logic [6:0] SHC_C_CLR_FIFO  = 7'h01;
  localparam logic [6:0] SHC_C_RST_DEV   = 7'h02;
  localparam logic [6:0] SHC_C_RST_BUS   = 7'h03;
  localparam logic [6:0] SHC_C_DMA_STOP  = 7'h04;
  localparam logic [6:0] SHC_C_SET_ATN   = 7'h1a;
  localparam logic [6:0] SHC_C_RESET_ATN = 7'h1b;
  localparam logic [6:0] SHC_C_RESEL     = 7'h40;
  localparam logic [6:0] SHC_C_SEL_ATN3  = 7'h46;

  typedef enum logic [2:0] {
    SHC_GRP_BAD,
    SHC_GRP_INIT,
    SHC_GRP_TARG,
    SHC_GRP_IDLE,
    SHC_GRP_GEN
  } shc_grp_t;

  typedef enum logic {
    SHC_ST_IDLE,
    SHC_ST_BUSY
  } shc_cmd_st_t;
endpackage : shc_pkg
`default_nettype wire

/* rtl/shc_cmd_status.sv */
// host register front end: count, fifo port, command queue and status
//
// Notes on behaviour
// - start count keeps its value through every reset until software rewrites it.
// - a zero start count loads as 65536 for a dma command.
// - fifo port is the bottom of a 16x9 fifo; write pushes, read pops.
// - only the fifo port is reachable through dma acknowledge with dma strobes.
// - fifo port clears on hard reset, soft reset and selection start.
// - command register holds two commands; the second runs after the first.
// - reset device and dma stop act at once, bypassing the queue.
// - command read returns the executing or the last executed command.
// - command bit 7 loads the counter from the start count.
// - initiator codes 10,11,12,18,1a,1b decode as their commands.
// - target codes 20-25,27-2b decode as their commands.
// - idle codes 40-46 decode as selection commands.
// - general codes 00-04 decode; 29 commands in four groups.
// - status stays latched until the interrupt status register is read.
// - phase bits latch only when phase latching is on, else live.
// - two pending interrupts; clearing the first loads the second.
// - status bit 7 mirrors interrupt; cleared by interrupt status read or reset.
// - illegal operation flag sets without interrupt; clears on interrupt status read.
// - parity error flag sets when checking enabled; clears like bit 6.
// - parity error as initiator in information phase raises attention.
// - count zero flag sets at zero, clears on load or reset only.
// - dma nop clears count zero; plain nop leaves it.
// - counter drops by one per byte, two per word.
// - interrupt status read clears the error flags and one pending interrupt, not count zero.
`timescale 1ns/1ps
`default_nettype none
module shc_cmd_status (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CS_N,
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  DIN,
  input  wire logic        DMA_ACKNOWLEDGE_N,
  input  wire logic        DMA_READ_STROBE_N,
  input  wire logic        DMA_WRITE_STROBE_N,
  input  wire logic [7:0]  INT_REASON,
  input  wire logic        CMD_DONE,
  input  wire logic        INT_EVENT,
  input  wire logic        SEL_START,
  input  wire logic        DIR_MISMATCH,
  input  wire logic        SYNC_PHASE_ERR,
  input  wire logic        PARITY_ERR,
  input  wire logic        PARITY_EN,
  input  wire logic        LATCH_PHASE,
  input  wire logic [2:0]  PHASE,
  input  wire logic        INITIATOR,
  input  wire logic        INFO_PHASE,
  input  wire logic        XFER_BYTE,
  input  wire logic        XFER_WORD,
  input  wire logic        SCSI_PUSH,
  input  wire logic [8:0]  SCSI_PUSH_DATA,
  input  wire logic        SCSI_POP,
  output logic [7:0]       DOUT,
  output logic             INT_N,
  output logic             ATN_OUT,
  output logic             CMD_START,
  output logic [7:0]       CMD_CODE,
  output logic [2:0]       CMD_GROUP,
  output logic             CMD_BUSY,
  output logic             DMA_STOP,
  output logic [16:0]      CUR_COUNT,
  output logic             COUNT_ZERO,
  output logic [8:0]       FIFO_HEAD,
  output logic [4:0]       FIFO_LEVEL
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       rd_prev;
    logic                       wr_prev;
    logic [7:0]                 dout;
    logic                       int_n;
    logic [1:0]                 int_cnt;
    logic                       illegal_op_flag;
    logic                       pe;
    logic                       ioe2;
    logic                       pe2;
    logic [2:0]                 phase;
    logic                       count_zero_flag;
    logic [16:0]                cnt;
    logic                       atn;
    shc_pkg::shc_cmd_st_t       st;
    logic [7:0]                 cmd_exec;
    logic [7:0]                 cmd_pend;
    logic                       pend_v;
    logic                       cmd_start;
    logic [2:0]                 cmd_grp;
    logic                       dma_stop;
    logic [15:0][8:0]           mem;
    logic [3:0]                 wp;
    logic [3:0]                 rp;
    logic [4:0]                 fcnt;
    logic [8:0]                 head;
  } shc_state_t;

  shc_state_t  q;
  shc_state_t  d;
  logic [15:0] stc_q;
  logic [15:0] stc_d;
  logic        rd_now;
  logic        wr_now;
  logic        rd_edge;
  logic        wr_edge;
  logic        dma_acknowledge_acc;
  logic [3:0]  acc_addr;
  logic        isr_rd;
  logic        soft_rst;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic shc_pkg::shc_grp_t cmd_group(input logic [6:0] c);
    shc_pkg::shc_grp_t g;
    g = shc_pkg::SHC_GRP_BAD;
    case (c)
      7'h10, 7'h11, 7'h12, 7'h18, 7'h1a, 7'h1b: g = shc_pkg::SHC_GRP_INIT;
      7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h27,
      7'h28, 7'h29, 7'h2a, 7'h2b:               g = shc_pkg::SHC_GRP_TARG;
      7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45,
      7'h46:                                    g = shc_pkg::SHC_GRP_IDLE;
      7'h00, 7'h01, 7'h02, 7'h03, 7'h04:        g = shc_pkg::SHC_GRP_GEN;
      default:                                  g = shc_pkg::SHC_GRP_BAD;
    endcase
    return g;
  endfunction : cmd_group

  // launch one command from the queue
  function automatic shc_state_t start_cmd(input shc_state_t s, input logic [7:0] c, input logic [15:0] stc);
    shc_state_t r;
    r = s;
    r.cmd_exec  = c;
    r.st        = shc_pkg::SHC_ST_BUSY;
    r.cmd_start = 1'b1;
    r.cmd_grp   = cmd_group(c[6:0]);
    if (c[shc_pkg::SHC_CMD_DMA_BIT]) begin
      r.cnt = (stc == 16'h0000) ? shc_pkg::SHC_MAX_COUNT : {1'b0, stc};
      r.count_zero_flag = 1'b0;
    end
    if (c[6:0] == shc_pkg::SHC_C_SET_ATN) begin
      r.atn = 1'b1;
    end
    if (c[6:0] == shc_pkg::SHC_C_RESET_ATN) begin
      r.atn = 1'b0;
    end
    return r;
  endfunction : start_cmd

  // ----------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------
  assign dma_acknowledge_acc = !DMA_ACKNOWLEDGE_N && (!DMA_READ_STROBE_N || !DMA_WRITE_STROBE_N);
  assign rd_now   = (!CS_N && !RD_N) || (!DMA_ACKNOWLEDGE_N && !DMA_READ_STROBE_N);
  assign wr_now   = (!CS_N && !WR_N) || (!DMA_ACKNOWLEDGE_N && !DMA_WRITE_STROBE_N);
  assign rd_edge  = rd_now && !q.rd_prev;
  assign wr_edge  = wr_now && !q.wr_prev;
  assign acc_addr = dma_acknowledge_acc ? shc_pkg::SHC_ADDR_FIFO : ADDR;
  assign isr_rd   = rd_edge && (acc_addr == shc_pkg::SHC_ADDR_ISR);
  assign soft_rst = wr_edge && (acc_addr == shc_pkg::SHC_ADDR_CMD) && (DIN[6:0] == shc_pkg::SHC_C_RST_DEV);

  // ----------------------------------------------------------------
  // start count, no reset at all
  // ----------------------------------------------------------------
  always_comb begin
    stc_d = stc_q;
    if (wr_edge && acc_addr == shc_pkg::SHC_ADDR_CNT_LO) begin
      stc_d[7:0] = DIN;
    end
    if (wr_edge && acc_addr == shc_pkg::SHC_ADDR_CNT_HI) begin
      stc_d[15:8] = DIN;
    end
  end

  always_ff @(posedge CLK) begin
    stc_q <= stc_d;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       push;
    logic       pop;
    logic [8:0] pdata;
    logic       fclr;
    logic       ioe_set;
    logic       pe_set;
    logic [1:0] dec;
    logic [2:0] ic;
    push    = 1'b0;
    pop     = 1'b0;
    pdata   = 9'h000;
    fclr    = 1'b0;
    ioe_set = DIR_MISMATCH || (SYNC_PHASE_ERR && INITIATOR);
    pe_set  = PARITY_ERR && PARITY_EN;
    dec     = XFER_WORD ? 2'd2 : (XFER_BYTE ? 2'd1 : 2'd0);
    ic      = 3'd0;
    d           = q;
    d.rd_prev   = rd_now;
    d.wr_prev   = wr_now;
    d.cmd_start = 1'b0;
    d.dma_stop  = 1'b0;

    // transfer counter
    if (dec != 2'd0 && q.cnt != 17'h00000) begin
      d.cnt = (q.cnt > {15'h0000, dec}) ? q.cnt - {15'h0000, dec} : 17'h00000;
      if (d.cnt == 17'h00000) begin
        d.count_zero_flag = 1'b1;
      end
    end

    // attention on parity fault
    if (pe_set && INITIATOR && INFO_PHASE) begin
      d.atn = 1'b1;
    end

    // command completion, then a new write
    if (CMD_DONE && q.st == shc_pkg::SHC_ST_BUSY) begin
      if (q.pend_v) begin
        d        = start_cmd(d, q.cmd_pend, stc_q);
        d.pend_v = 1'b0;
      end else begin
        d.st = shc_pkg::SHC_ST_IDLE;
      end
    end
    if (wr_edge && acc_addr == shc_pkg::SHC_ADDR_CMD) begin
      if (DIN[6:0] == shc_pkg::SHC_C_DMA_STOP) begin
        d.dma_stop = 1'b1;
      end else if (d.st == shc_pkg::SHC_ST_IDLE) begin
        d = start_cmd(d, DIN, stc_q);
        if (DIN[6:0] == shc_pkg::SHC_C_CLR_FIFO || DIN[6:0] == shc_pkg::SHC_C_RESEL ||
            (DIN[6:0] >= 7'h41 && DIN[6:0] <= 7'h43) || DIN[6:0] == shc_pkg::SHC_C_SEL_ATN3) begin
          fclr = 1'b1;
        end
      end else begin
        if (d.pend_v) begin
          ioe_set = 1'b1;
        end
        d.cmd_pend = DIN;
        d.pend_v   = 1'b1;
      end
    end

    // fifo requests
    if (wr_edge && acc_addr == shc_pkg::SHC_ADDR_FIFO) begin
      push  = 1'b1;
      pdata = {~^DIN, DIN};
    end else if (SCSI_PUSH) begin
      push  = 1'b1;
      pdata = SCSI_PUSH_DATA;
    end
    pop = (rd_edge && acc_addr == shc_pkg::SHC_ADDR_FIFO) || SCSI_POP;
    if (SEL_START) begin
      fclr = 1'b1;
    end
    if (fclr) begin
      d.mem  = '0;
      d.wp   = 4'h0;
      d.rp   = 4'h0;
      d.fcnt = 5'd0;
    end else begin
      if (pop && q.fcnt != 5'd0) begin
        d.rp   = q.rp + 4'h1;
        d.fcnt = d.fcnt - 5'd1;
      end
      if (push) begin
        if (q.fcnt == 5'd16 && !(pop && q.fcnt != 5'd0)) begin
          ioe_set = 1'b1;
        end else begin
          d.mem[q.wp] = pdata;
          d.wp        = q.wp + 4'h1;
          d.fcnt      = d.fcnt + 5'd1;
        end
      end
    end
    d.head = (d.fcnt == 5'd0) ? 9'h000 : d.mem[d.rp];

    // register read data
    if (rd_edge) begin
      case (acc_addr)
        shc_pkg::SHC_ADDR_CNT_LO: d.dout = q.cnt[7:0];
        shc_pkg::SHC_ADDR_CNT_HI: d.dout = q.cnt[15:8];
        shc_pkg::SHC_ADDR_FIFO:   d.dout = q.head[7:0];
        shc_pkg::SHC_ADDR_CMD:    d.dout = q.cmd_exec;
        shc_pkg::SHC_ADDR_STAT:   d.dout = {~q.int_n, q.illegal_op_flag, q.pe, q.count_zero_flag, 1'b0,
                                            LATCH_PHASE ? q.phase : PHASE};
        shc_pkg::SHC_ADDR_ISR:    d.dout = INT_REASON;
        default:                  d.dout = 8'h00;
      endcase
    end

    // interrupt and status flags, a new event wins over the clear
    ic = {1'b0, q.int_cnt};
    if (isr_rd && ic != 3'd0) begin
      ic = ic - 3'd1;
    end
    if (INT_EVENT && ic != 3'd2) begin
      ic = ic + 3'd1;
      if (ic == 3'd1 || !isr_rd) begin
        d.phase = PHASE;
      end
    end
    if (isr_rd) begin
      d.illegal_op_flag  = (q.int_cnt == 2'd2) ? q.ioe2 : 1'b0;
      d.pe   = (q.int_cnt == 2'd2) ? q.pe2 : 1'b0;
      d.ioe2 = 1'b0;
      d.pe2  = 1'b0;
    end
    if (ioe_set) begin
      d.illegal_op_flag = 1'b1;
    end
    if (pe_set) begin
      d.pe = 1'b1;
    end
    if ((ioe_set || pe_set) && q.int_cnt == 2'd2 && !isr_rd) begin
      d.ioe2 = q.ioe2 || ioe_set;
      d.pe2  = q.pe2 || pe_set;
    end
    d.int_cnt = ic[1:0];
    d.int_n   = (ic == 3'd0);

    // reset device command returns all state but the start count and the strobe history to its reset value
    if (soft_rst) begin
      d         = '0;
      d.int_n   = 1'b1;
      d.rd_prev = rd_now;
      d.wr_prev = wr_now;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q       <= '0;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign DOUT       = q.dout;
  assign INT_N      = q.int_n;
  assign ATN_OUT    = q.atn;
  assign CMD_START  = q.cmd_start;
  assign CMD_CODE   = q.cmd_exec;
  assign CMD_GROUP  = q.cmd_grp;
  assign CMD_BUSY   = (q.st == shc_pkg::SHC_ST_BUSY);
  assign DMA_STOP   = q.dma_stop;
  assign CUR_COUNT  = q.cnt;
  assign COUNT_ZERO = q.count_zero_flag;
  assign FIFO_HEAD  = q.head;
  assign FIFO_LEVEL = q.fcnt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  property p_stc_hold;
    !(wr_edge && (acc_addr == shc_pkg::SHC_ADDR_CNT_LO || acc_addr == shc_pkg::SHC_ADDR_CNT_HI)) |=> $stable(stc_q);
  endproperty
  a_stc_hold: assert property (p_stc_hold) else $error("start count changed without a write");

  property p_zero_max;
    (CMD_DONE == 1'b0 && q.st == shc_pkg::SHC_ST_IDLE && !soft_rst && wr_edge && acc_addr == shc_pkg::SHC_ADDR_CMD
     && DIN[7] && DIN[6:0] != shc_pkg::SHC_C_DMA_STOP && stc_q == 16'h0000) |=> (q.cnt == 17'h10000 && !q.count_zero_flag);
  endproperty
  a_zero_max: assert property (p_zero_max) else $error("zero start count did not load maximum");

  property p_fifo_push;
    (wr_edge && acc_addr == shc_pkg::SHC_ADDR_FIFO && !SCSI_POP && !SEL_START && !soft_rst && q.fcnt < 5'd16
     && !(wr_edge && dma_acknowledge_acc == 1'b0 && ADDR == shc_pkg::SHC_ADDR_CMD)) |=> q.fcnt == $past(q.fcnt) + 5'd1;
  endproperty
  a_fifo_push: assert property (p_fifo_push) else $error("fifo write did not push");

  property p_sel_clear;
    SEL_START |=> (q.fcnt == 5'd0 && q.head == 9'h000);
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("fifo not cleared at selection");

  property p_queue;
    (wr_edge && acc_addr == shc_pkg::SHC_ADDR_CMD && q.st == shc_pkg::SHC_ST_BUSY && !CMD_DONE && !q.pend_v
     && DIN[6:0] != shc_pkg::SHC_C_DMA_STOP && !soft_rst) |=> (q.pend_v && q.cmd_exec == $past(q.cmd_exec));
  endproperty
  a_queue: assert property (p_queue) else $error("second command not queued");

  property p_reset_cmd;
    soft_rst |=> (!CMD_BUSY && INT_N && q.fcnt == 5'd0 && !q.illegal_op_flag);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not act at once");

  property p_byte_dec;
    (XFER_BYTE && !XFER_WORD && q.cnt > 17'h00001 && !CMD_DONE && !wr_edge) |=> q.cnt == $past(q.cnt) - 17'h00001;
  endproperty
  a_byte_dec: assert property (p_byte_dec) else $error("counter did not drop by one");

  property p_int_hold;
    (!INT_N && !isr_rd && !soft_rst) |=> !INT_N;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt released without status read");

  property p_ioe_set;
    (DIR_MISMATCH && !soft_rst) |=> q.illegal_op_flag;
  endproperty
  a_ioe_set: assert property (p_ioe_set) else $error("illegal operation flag not set");

  property p_ctz;
    (XFER_BYTE && !XFER_WORD && q.cnt == 17'h00001 && !CMD_DONE && !wr_edge) |=> (COUNT_ZERO ##1 (COUNT_ZERO || $past(wr_edge) || $past(soft_rst) || $past(CMD_DONE)));
  endproperty
  a_ctz: assert property (p_ctz) else $error("count zero flag not set at zero");

endmodule : shc_cmd_status
`default_nettype wire

/* verification/shc_seq_model.sv */
// command sequencer model: finishes each started command after a set delay
`timescale 1ns/1ps
`default_nettype none
module shc_seq_model #(
  parameter logic [7:0] REASON = 8'h08
) (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       CMD_START,
  input  wire logic [7:0] DELAY,
  output logic            CMD_DONE,
  output logic            INT_EVENT,
  output logic [7:0]      INT_REASON
);
  logic [7:0] cnt_q;
  logic       run_q;

  assign INT_REASON = REASON;
  // every finished command raises one interrupt
  assign INT_EVENT  = CMD_DONE;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q    <= 8'h00;
      run_q    <= 1'b0;
      CMD_DONE <= 1'b0;
    end else begin
      CMD_DONE <= 1'b0;
      if (CMD_START) begin
        run_q <= 1'b1;
        cnt_q <= DELAY;
      end else if (run_q) begin
        if (cnt_q == 8'h00) begin
          run_q    <= 1'b0;
          CMD_DONE <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule : shc_seq_model
`default_nettype wire

/* verification/shc_cmd_status_tb_top.sv */
// self-checking bench for the host command and status block
`timescale 1ns/1ps
`default_nettype none
module shc_cmd_status_tb_top;
  logic CLK, NRST, CS_N, RD_N, WR_N, DMA_ACKNOWLEDGE_N, DMA_READ_STROBE_N, DMA_WRITE_STROBE_N, CMD_DONE, INT_EVENT, SEL_START;
  logic DIR_MISMATCH, PARITY_ERR, PARITY_EN, LATCH_PHASE, INITIATOR, INFO_PHASE, XFER_BYTE, XFER_WORD;
  logic INT_N, ATN_OUT, CMD_START, CMD_BUSY, DMA_STOP, COUNT_ZERO;
  logic [3:0]  ADDR;
  logic [7:0]  DIN, DOUT, INT_REASON, CMD_CODE, DELAY;
  logic [2:0]  PHASE, CMD_GROUP;
  logic [16:0] CUR_COUNT;
  logic [8:0]  FIFO_HEAD;
  logic [4:0]  FIFO_LEVEL;
  int errors, comparisons, cycles, starts, stops, mark;
  // command code beside the group it decodes to
  logic [10:0] rows [28] = '{
    {8'h10,3'h1}, {8'h11,3'h1}, {8'h12,3'h1}, {8'h18,3'h1}, {8'h1a,3'h1}, {8'h1b,3'h1},
    {8'h20,3'h2}, {8'h21,3'h2}, {8'h22,3'h2}, {8'h23,3'h2}, {8'h24,3'h2}, {8'h25,3'h2},
    {8'h27,3'h2}, {8'h28,3'h2}, {8'h29,3'h2}, {8'h2a,3'h2}, {8'h2b,3'h2}, {8'h40,3'h3},
    {8'h41,3'h3}, {8'h42,3'h3}, {8'h43,3'h3}, {8'h44,3'h3}, {8'h45,3'h3}, {8'h46,3'h3},
    {8'h00,3'h4}, {8'h01,3'h4}, {8'h03,3'h4}, {8'h30,3'h0}};

  shc_cmd_status dut (.CLK(CLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR),
    .DIN(DIN), .DMA_ACKNOWLEDGE_N(DMA_ACKNOWLEDGE_N), .DMA_READ_STROBE_N(DMA_READ_STROBE_N), .DMA_WRITE_STROBE_N(DMA_WRITE_STROBE_N), .INT_REASON(INT_REASON),
    .CMD_DONE(CMD_DONE), .INT_EVENT(INT_EVENT), .SEL_START(SEL_START), .DIR_MISMATCH(DIR_MISMATCH),
    .SYNC_PHASE_ERR(1'b0), .PARITY_ERR(PARITY_ERR), .PARITY_EN(PARITY_EN), .LATCH_PHASE(LATCH_PHASE),
    .PHASE(PHASE), .INITIATOR(INITIATOR), .INFO_PHASE(INFO_PHASE), .XFER_BYTE(XFER_BYTE),
    .XFER_WORD(XFER_WORD), .SCSI_PUSH(1'b0), .SCSI_PUSH_DATA(9'h000), .SCSI_POP(1'b0), .DOUT(DOUT),
    .INT_N(INT_N), .ATN_OUT(ATN_OUT), .CMD_START(CMD_START), .CMD_CODE(CMD_CODE),
    .CMD_GROUP(CMD_GROUP), .CMD_BUSY(CMD_BUSY), .DMA_STOP(DMA_STOP), .CUR_COUNT(CUR_COUNT),
    .COUNT_ZERO(COUNT_ZERO), .FIFO_HEAD(FIFO_HEAD), .FIFO_LEVEL(FIFO_LEVEL));

  shc_seq_model seq (.CLK(CLK), .NRST(NRST), .CMD_START(CMD_START), .DELAY(DELAY),
    .CMD_DONE(CMD_DONE), .INT_EVENT(INT_EVENT), .INT_REASON(INT_REASON));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // one-cycle strobes counted while they stand
  always @(negedge CLK) begin
    if (CMD_START === 1'b1) starts++;
    if (DMA_STOP === 1'b1) stops++;
  end

  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one access held for one edge, then a gap; read data settled on return
  task automatic bus(input logic dma, input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge CLK);
    ADDR = a;
    DIN  = d;
    if (dma) {DMA_ACKNOWLEDGE_N, DMA_READ_STROBE_N, DMA_WRITE_STROBE_N} = {1'b0, wr, !wr};
    else {CS_N, RD_N, WR_N} = {1'b0, wr, !wr};
    @(negedge CLK);
    {CS_N, RD_N, WR_N, DMA_ACKNOWLEDGE_N, DMA_READ_STROBE_N, DMA_WRITE_STROBE_N} = 6'h3f;
    @(negedge CLK);
  endtask : bus

  task automatic wait_idle();
    for (int i = 0; i < 60 && CMD_BUSY !== 1'b0; i++) @(negedge CLK);
    check(CMD_BUSY, 1'b0);
  endtask : wait_idle

  task automatic cmd(input logic [7:0] c);
    wait_idle();
    bus(0, 1, 4'h3, c);
  endtask : cmd

  task automatic stc(input logic [15:0] v);
    bus(0, 1, 4'h0, v[7:0]);
    bus(0, 1, 4'h1, v[15:8]);
  endtask : stc

  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
    @(negedge CLK);
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {CS_N, RD_N, WR_N, DMA_ACKNOWLEDGE_N, DMA_READ_STROBE_N, DMA_WRITE_STROBE_N} = 6'h3f;
    {SEL_START, DIR_MISMATCH, PARITY_ERR, PARITY_EN, LATCH_PHASE, INITIATOR} = 6'h00;
    {INFO_PHASE, XFER_BYTE, XFER_WORD} = 3'h0;
    {ADDR, DIN, PHASE, DELAY} = {4'h0, 8'h00, 3'h0, 8'h02};
    NRST = 1'b0;
    repeat (4) @(negedge CLK);
    // count has no reset, so it is given a value while reset is held
    stc(16'h0004);
    check({INT_N, DOUT, FIFO_LEVEL, COUNT_ZERO, CMD_BUSY}, {1'b1, 8'h00, 5'h00, 1'b0, 1'b0});
    NRST = 1'b1;
    foreach (rows[i]) begin
      mark = starts;
      cmd(rows[i][10:3]);
      check({CMD_CODE, CMD_GROUP}, rows[i]);
      check(17'(starts - mark), 17'h00001);
    end
    // count load, zero flag and reset survival
    stc(16'h0000);
    cmd(8'h80);
    check({CUR_COUNT, COUNT_ZERO}, {17'h10000, 1'b0});
    stc(16'h0004);
    cmd(8'h90);
    check(CUR_COUNT, 17'h00004);
    pulse(XFER_BYTE);
    check(CUR_COUNT, 17'h00003);
    pulse(XFER_WORD);
    check(CUR_COUNT, 17'h00001);
    pulse(XFER_BYTE);
    check({CUR_COUNT, COUNT_ZERO}, {17'h00000, 1'b1});
    cmd(8'h00);
    check(COUNT_ZERO, 1'b1);
    bus(0, 0, 4'h5, 8'h00);
    check(COUNT_ZERO, 1'b1);
    wait_idle();
    bus(0, 1, 4'h3, 8'h02);
    check({COUNT_ZERO, INT_N}, {1'b0, 1'b1});
    cmd(8'h80);
    check({CUR_COUNT, COUNT_ZERO}, {17'h00004, 1'b0});
    // fifo port by host and by dma acknowledge
    bus(0, 1, 4'h2, 8'h5a);
    bus(1, 1, 4'h3, 8'ha5);
    check({FIFO_LEVEL, FIFO_HEAD}, {5'h02, 9'h15a});
    bus(1, 0, 4'h3, 8'h00);
    check(DOUT, 8'h5a);
    bus(0, 0, 4'h2, 8'h00);
    check(DOUT, 8'ha5);
    bus(0, 0, 4'h2, 8'h00);
    check({DOUT, FIFO_LEVEL}, {8'h00, 5'h00});
    bus(0, 1, 4'h2, 8'h33);
    pulse(SEL_START);
    check({FIFO_LEVEL, FIFO_HEAD}, {5'h00, 9'h000});
    // queue of two, overwrite, immediate stop, two interrupts
    wait_idle();
    bus(0, 0, 4'h5, 8'h00);
    bus(0, 0, 4'h5, 8'h00);
    DELAY = 8'h14;
    cmd(8'h10);
    bus(0, 1, 4'h3, 8'h11);
    bus(0, 0, 4'h3, 8'h00);
    check(DOUT, 8'h10);
    bus(0, 1, 4'h3, 8'h12);
    bus(0, 0, 4'h4, 8'h00);
    check(DOUT[6], 1'b1);
    mark = stops;
    bus(0, 1, 4'h3, 8'h04);
    check(17'(stops - mark), 17'h00001);
    check(CMD_BUSY, 1'b1);
    for (int i = 0; i < 60 && CMD_START !== 1'b1; i++) @(negedge CLK);
    check({CMD_START, CMD_CODE}, {1'b1, 8'h12});
    bus(0, 0, 4'h3, 8'h00);
    check(DOUT, 8'h12);
    wait_idle();
    bus(0, 0, 4'h4, 8'h00);
    check({INT_N, DOUT[7]}, 2'h1);
    bus(0, 0, 4'h5, 8'h00);
    check({INT_N, DOUT}, {1'b0, INT_REASON});
    bus(0, 0, 4'h5, 8'h00);
    bus(0, 0, 4'h4, 8'h00);
    check({INT_N, DOUT[7:6]}, 3'h4);
    pulse(DIR_MISMATCH);
    bus(0, 0, 4'h4, 8'h00);
    check({INT_N, DOUT[6]}, 2'h3);
    // parity, attention and phase bits
    DELAY = 8'h02;
    {PARITY_EN, INITIATOR, INFO_PHASE, PHASE} = {3'h7, 3'h5};
    pulse(PARITY_ERR);
    bus(0, 0, 4'h4, 8'h00);
    check({ATN_OUT, INT_N, DOUT[5], DOUT[2:0]}, {3'h7, 3'h5});
    {LATCH_PHASE, PHASE} = {1'b1, 3'h6};
    cmd(8'h00);
    wait_idle();
    PHASE = 3'h1;
    bus(0, 0, 4'h4, 8'h00);
    check({DOUT[7], DOUT[2:0]}, {1'b1, 3'h6});
    bus(0, 0, 4'h5, 8'h00);
    bus(0, 0, 4'h4, 8'h00);
    check({INT_N, DOUT[7], DOUT[5]}, 3'h4);
    // hard reset while idle keeps the start count
    @(negedge CLK);
    NRST = 1'b0;
    @(negedge CLK);
    check({INT_N, COUNT_ZERO, CMD_BUSY, FIFO_LEVEL}, {1'b1, 1'b0, 1'b0, 5'h00});
    NRST = 1'b1;
    cmd(8'h80);
    check(CUR_COUNT, 17'h00004);
    conclude();
  end
endmodule : shc_cmd_status_tb_top
`default_nettype wire
